/* hw/pmi_consts.svh */
`ifndef PMI_CONSTS_SVH
`define PMI_CONSTS_SVH
// Register word byte addresses
`define PMI_A_ENABLE    8'h00
`define PMI_A_STATUS    8'h04
`define PMI_A_MASK      8'h08
`define PMI_A_MODE      8'h0C
`define PMI_A_TRAP_OP   8'h10
`define PMI_A_TRAP_PORT 8'h14
`define PMI_A_PWRDN     8'h18
`define PMI_A_DISP      8'h1C
`define PMI_A_RNG_LO    8'h20
`define PMI_A_RNG_HI    8'h40
`define PMI_A_TMR_RLD   8'h60
`define PMI_A_TMR_CNT   8'h80
// Enable and status bit positions
`define PMI_B_RANGE     0
`define PMI_B_TIMER     6
`define PMI_B_XBUS      12
`define PMI_B_EXT       13
`define PMI_B_TRAP      14
`define PMI_B_DISP      15
`define PMI_NSRC        16
// Private memory window
`define PMI_WIN_LO      24'h03_0000
`define PMI_WIN_HI      24'h03_FFFF
// Timer step
`define PMI_STEP_S      4
`define PMI_CLK_HZ      25000000
`endif

/* hw/pmi_ctrl.sv */
`timescale 1ns/1ps
`include "pmi_consts.svh"
module pmi_ctrl #(
   parameter int NRNG      = 6,
   parameter int TW        = 16,
   parameter int STEP_CYC  = `PMI_STEP_S * `PMI_CLK_HZ,
   parameter int REFR_DIV  = 390
) (
   input  wire logic        clk_sys,           // System clock 25 MHz
   input  wire logic        rst_n,             // Async reset, active low
   input  wire logic [7:0]  avs_address,       // Byte address
   input  wire logic        avs_read,          // Read request
   input  wire logic        avs_write,         // Write request
   input  wire logic [31:0] avs_writedata,     // Write data
   output logic [31:0]      avs_readdata,      // Read data
   output logic             avs_waitrequest,   // Stall
   input  wire logic        io_valid,          // Core I/O cycle
   input  wire logic        io_write,          // I/O direction
   input  wire logic [15:0] io_port,           // I/O port address
   input  wire logic [7:0]  io_opcode,         // Instruction opcode
   input  wire logic        mem_valid,         // Core memory cycle
   input  wire logic [23:0] mem_addr,          // Memory address
   input  wire logic [5:0]  periph_access,     // Peripheral accessed
   input  wire logic        xbus_irq,          // Expansion bus interrupt
   input  wire logic        ext_req,           // External request pin
   input  wire logic        nmi_req,           // Non-maskable interrupt
   input  wire logic        intr_req,          // Maskable interrupt
   input  wire logic        core_ack,          // Core took state step
   input  wire logic        resume_exec,       // Resume instruction executed
   input  wire logic [1:0]  core_opmode,       // Current core mode
   output logic             mgmt_mode,         // In management mode
   output logic             mgmt_irq_take,     // Vector to handler
   output logic             nmi_take,          // Forward NMI
   output logic             intr_take,         // Forward INTR
   output logic             pmem_enable,       // Private memory decode
   output logic             pmem_hit,          // Access hits private window
   output logic             state_save,        // Save state to private memory
   output logic             state_restore,     // Restore state
   output logic             mgmt_stack_sel,    // Dedicated stack select
   output logic             force_real,        // Force real mode
   output logic             backlight_on,      // Backlight power
   output logic             disp_refresh,      // Display refresh strobe
   output logic             irq                // Status interrupt
);
   localparam int CW = $clog2(STEP_CYC + 1);
   localparam int RW = $clog2(REFR_DIV + 1);
   localparam int NS = `PMI_NSRC;

   typedef struct packed {
      pmi_pkg::pmi_state_t     st;
      logic [NS-1:0]           en;
      logic [NS-1:0]           status;
      logic [NS-1:0]           mask;
      logic [5:0]              pwrdn;
      logic [7:0]              trap_op;
      logic [15:0]             trap_port;
      logic [NRNG-1:0][15:0]   rlo;
      logic [NRNG-1:0][15:0]   rhi;
      logic [5:0][TW-1:0]      rld;
      logic [5:0][TW-1:0]      cnt;
      logic [TW-1:0]           drld;
      logic [TW-1:0]           dcnt;
      logic [15:0]             dport_lo;
      logic [15:0]             dport_hi;
      logic [CW-1:0]           step;
      logic [RW-1:0]           rdiv;
      logic [31:0]             rdata;
      logic                    ack;
      logic                    mode;
      logic                    take;
      logic                    nmi_t;
      logic                    intr_t;
      logic                    pmem_hit;
      logic                    save;
      logic                    rest;
      logic                    real_f;
      logic                    bl;
      logic                    refr;
      logic                    irq;
   } pmi_regs_t;

   pmi_regs_t r, n;

   function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
      in_range = (a >= lo) && (a <= hi);
   endfunction

   // Word decode for the register arrays, shared by the write and read paths
   function automatic logic at_word(input logic [7:0] a, input logic [7:0] base, input int i);
      at_word = (a == base + 8'(4*i));
   endfunction

   logic [NS-1:0] ev;
   logic [NRNG-1:0] rng_hit;
   logic [5:0] tmr_uf;
   logic step_tick, disp_hit, port_trap, pend, blk;
   logic [2:0] pidx;

   genvar g;
   generate
      for (g = 0; g < NRNG; g++) begin : g_rng
         assign rng_hit[g] = io_valid && in_range(io_port, r.rlo[g], r.rhi[g]);
      end
      for (g = 0; g < 6; g++) begin : g_tmr
         assign tmr_uf[g] = step_tick && !periph_access[g] && (r.cnt[g] == TW'(1));
      end
   endgenerate

   assign step_tick = (r.step == CW'(0));
   assign pidx      = io_port[2:0];
   assign port_trap = io_valid && (pidx < 3'd6) && r.pwrdn[pidx];
   assign disp_hit  = (io_valid && in_range(io_port, r.dport_lo, r.dport_hi))
                    || (mem_valid && mem_addr[23:17] == 7'h05);

   always_comb begin
      ev = '0;
      ev[`PMI_B_RANGE +: 6]  = 6'(rng_hit);
      ev[`PMI_B_TIMER +: 6]  = tmr_uf;
      ev[`PMI_B_XBUS]        = xbus_irq;
      ev[`PMI_B_EXT]         = ext_req;
      ev[`PMI_B_TRAP]        = port_trap;
      ev[`PMI_B_DISP]        = step_tick && !disp_hit && (r.dcnt == TW'(1));
   end

   // External pin and port traps bypass the enable gating
   assign pend = |(r.status & (r.en | (NS'(1) << `PMI_B_EXT) | (NS'(1) << `PMI_B_TRAP)));

   // A request arriving this cycle already blocks forwarding, closing a one-cycle gap
   assign blk = pend || |(ev & (r.en | (NS'(1) << `PMI_B_EXT) | (NS'(1) << `PMI_B_TRAP)));

   always_comb begin
      n = r;
      n.take = 1'b0;
      n.save = 1'b0;
      n.rest = 1'b0;
      n.refr = 1'b0;
      n.ack  = 1'b0;
      n.step = step_tick ? CW'(STEP_CYC - 1) : CW'(r.step - CW'(1));
      for (int i = 0; i < 6; i++) begin
         if (periph_access[i]) begin
            n.cnt[i] = r.rld[i];
         end else if (step_tick && r.cnt[i] != '0) begin
            n.cnt[i] = r.cnt[i] - TW'(1);
         end
      end
      if (disp_hit) begin
         n.dcnt = r.drld;
         n.bl   = 1'b1;
      end else if (step_tick && r.dcnt != '0) begin
         n.dcnt = r.dcnt - TW'(1);
         if (r.dcnt == TW'(1)) begin
            // Only the backlight drops; refresh below is not touched
            n.bl = 1'b0;
         end
      end
      // Refresh keeps running regardless of backlight, one strobe every REFR_DIV cycles
      if (r.rdiv == RW'(0)) begin
         n.rdiv = RW'(REFR_DIV - 1);
         n.refr = 1'b1;
      end else begin
         n.rdiv = r.rdiv - RW'(1);
      end
      if (port_trap) begin
         n.trap_op   = io_opcode;
         n.trap_port = io_port;
      end
      n.pmem_hit = 1'b0;
      if (r.mode && mem_valid) begin
         // Window is invisible outside management mode
         n.pmem_hit = (mem_addr >= `PMI_WIN_LO) && (mem_addr <= `PMI_WIN_HI);
      end
      // NMI and INTR only pass when no management request is pending or arriving
      n.nmi_t  = 1'b0;
      n.intr_t = 1'b0;
      if (!blk && r.st == pmi_pkg::PMI_NORMAL) begin
         n.nmi_t  = nmi_req;
         n.intr_t = intr_req && !nmi_req;
      end
      case (r.st)
         pmi_pkg::PMI_NORMAL: if (pend) begin
            n.st   = pmi_pkg::PMI_ENTER;
            n.mode = 1'b1;
            n.save = 1'b1;
         end
         pmi_pkg::PMI_ENTER: if (core_ack) begin
            n.st     = pmi_pkg::PMI_ACTIVE;
            n.take   = 1'b1;
            n.real_f = core_opmode != 2'(pmi_pkg::PMI_OPM_REAL) || 1'b1;
         end
         pmi_pkg::PMI_ACTIVE: if (resume_exec) begin
            n.st   = pmi_pkg::PMI_EXIT;
            n.rest = 1'b1;
         end
         pmi_pkg::PMI_EXIT: if (core_ack) begin
            // Memory stays decoded until the core reports the restore done
            n.st     = pmi_pkg::PMI_NORMAL;
            n.mode   = 1'b0;
            n.real_f = 1'b0;
         end
         default: begin
            n.st = pmi_pkg::PMI_NORMAL;
         end
      endcase
      // Register access: one wait state, answer on the second edge
      if ((avs_read || avs_write) && !r.ack) begin
         n.ack = 1'b1;
         if (avs_write) begin
            if (avs_address == `PMI_A_ENABLE) begin
               n.en = avs_writedata[NS-1:0];
            end else if (avs_address == `PMI_A_STATUS) begin
               // Write-one clears, on top of the clear on read
               n.status = r.status & ~avs_writedata[NS-1:0];
            end else if (avs_address == `PMI_A_MASK) begin
               n.mask = avs_writedata[NS-1:0];
            end else if (avs_address == `PMI_A_PWRDN) begin
               n.pwrdn = avs_writedata[5:0];
            end else if (avs_address == `PMI_A_DISP) begin
               n.drld = avs_writedata[TW-1:0];
               n.dcnt = avs_writedata[TW-1:0];
            end else if (avs_address == `PMI_A_TRAP_OP) begin
               // Trap opcode is read only, so its write slot sets the display port range
               n.dport_lo = avs_writedata[15:0];
               n.dport_hi = avs_writedata[31:16];
            end
            for (int i = 0; i < NRNG; i++) begin
               if (at_word(avs_address, `PMI_A_RNG_LO, i)) begin
                  n.rlo[i] = avs_writedata[15:0];
               end
               if (at_word(avs_address, `PMI_A_RNG_HI, i)) begin
                  n.rhi[i] = avs_writedata[15:0];
               end
            end
            for (int i = 0; i < 6; i++) begin
               if (at_word(avs_address, `PMI_A_TMR_RLD, i)) begin
                  // Loading the period restarts the count at once
                  n.rld[i] = avs_writedata[TW-1:0];
                  n.cnt[i] = avs_writedata[TW-1:0];
               end
            end
         end else begin
            n.rdata = 32'h0000_0000;
            if (avs_address == `PMI_A_ENABLE) begin
               n.rdata = 32'(r.en);
            end else if (avs_address == `PMI_A_STATUS) begin
               n.rdata  = 32'(r.status);
               n.status = '0;
            end else if (avs_address == `PMI_A_MASK) begin
               n.rdata = 32'(r.mask);
            end else if (avs_address == `PMI_A_MODE) begin
               n.rdata = {29'h0, r.bl, r.st};
            end else if (avs_address == `PMI_A_TRAP_OP) begin
               n.rdata = {24'h00_0000, r.trap_op};
            end else if (avs_address == `PMI_A_TRAP_PORT) begin
               n.rdata = {16'h0000, r.trap_port};
            end else if (avs_address == `PMI_A_PWRDN) begin
               n.rdata = {26'h000_0000, r.pwrdn};
            end else if (avs_address == `PMI_A_DISP) begin
               n.rdata = 32'(r.dcnt);
            end
            for (int i = 0; i < NRNG; i++) begin
               if (at_word(avs_address, `PMI_A_RNG_LO, i)) begin
                  n.rdata = {16'h0000, r.rlo[i]};
               end
               if (at_word(avs_address, `PMI_A_RNG_HI, i)) begin
                  n.rdata = {16'h0000, r.rhi[i]};
               end
            end
            for (int i = 0; i < 6; i++) begin
               if (at_word(avs_address, `PMI_A_TMR_RLD, i)) begin
                  n.rdata = 32'(r.rld[i]);
               end
               if (at_word(avs_address, `PMI_A_TMR_CNT, i)) begin
                  n.rdata = 32'(r.cnt[i]);
               end
            end
         end
      end
      // Set wins over a clear in the same cycle
      n.status = n.status | ev;
      n.irq = |(n.status & n.mask);
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign avs_readdata    = r.rdata;
   assign avs_waitrequest = !r.ack;
   assign mgmt_mode       = r.mode;
   assign mgmt_irq_take   = r.take;
   assign nmi_take        = r.nmi_t;
   assign intr_take       = r.intr_t;
   assign pmem_enable     = r.mode;
   assign pmem_hit        = r.pmem_hit;
   assign state_save      = r.save;
   assign state_restore   = r.rest;
   assign mgmt_stack_sel  = r.mode;
   assign force_real      = r.real_f;
   assign backlight_on    = r.bl;
   assign disp_refresh    = r.refr;
   assign irq             = r.irq;
endmodule

/* hw/pmi_pkg.sv */
package pmi_pkg;
   typedef enum logic [1:0] {PMI_NORMAL, PMI_ENTER, PMI_ACTIVE, PMI_EXIT} pmi_state_t;
   typedef enum logic [1:0] {PMI_OPM_REAL, PMI_OPM_PROT, PMI_OPM_VIRT} pmi_opmode_t;
endpackage

/* tb/pmi_core_mdl.sv */
`timescale 1ns/1ps
module pmi_core_mdl (
   input  wire logic clk_sys,        // Clock
   input  wire logic rst_n,          // Reset
   input  wire logic state_save,     // Save step
   input  wire logic state_restore,  // Restore step
   output logic      core_ack,       // Step done
   output logic [1:0] core_opmode    // Mode at request
);
   int unsigned dly;
   // Random step time and mode so entry never leans on a fixed core
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         dly         <= 0;
         core_ack    <= 1'b0;
         core_opmode <= 2'h0;
      end else begin
         core_ack <= (dly == 1);
         if (state_save || state_restore) begin
            dly         <= 1 + $urandom_range(3);
            core_opmode <= 2'($urandom_range(2));
         end else if (dly != 0) begin
            dly <= dly - 1;
         end
      end
   end
endmodule

/* tb/pmi_ctrl_properties.sv */
`timescale 1ns/1ps
module pmi_ctrl_props (
   input wire logic        clk_sys,          // Clock
   input wire logic        rst_n,            // Reset
   input wire logic        ext_req,          // External pin
   input wire logic [23:0] mem_addr,         // Memory address
   input wire logic        avs_waitrequest,  // Bus stall
   input wire logic        mgmt_mode,        // Mode
   input wire logic        mgmt_irq_take,    // Vector
   input wire logic        nmi_take,         // NMI out
   input wire logic        intr_take,        // INTR out
   input wire logic        pmem_enable,      // Window on
   input wire logic        pmem_hit,         // Window hit
   input wire logic        state_save,       // Save step
   input wire logic        state_restore,    // Restore step
   input wire logic        mgmt_stack_sel,   // Stack select
   input wire logic        force_real        // Real mode
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   property p_entry; $rose(mgmt_mode) |-> state_save; endproperty
   a_entry: assert property (p_entry) else $error("mode entered without save");
   property p_prio; mgmt_mode |-> !nmi_take && !intr_take; endproperty
   a_prio: assert property (p_prio) else $error("interrupt forwarded in mode");
   property p_win; pmem_hit |-> $past(mgmt_mode) && ($past(mem_addr) & 24'hff_0000) == 24'h03_0000; endproperty
   a_win: assert property (p_win) else $error("window hit out of range or mode");
   property p_sel; pmem_enable == mgmt_mode && mgmt_stack_sel == mgmt_mode; endproperty
   a_sel: assert property (p_sel) else $error("memory or stack select wrong");
   property p_real; mgmt_irq_take |=> force_real && mgmt_mode; endproperty
   a_real: assert property (p_real) else $error("handler not in real mode");
   property p_exit; state_restore |-> pmem_enable ##1 pmem_enable; endproperty
   a_exit: assert property (p_exit) else $error("memory off before restore");
   property p_ext; ext_req && !mgmt_mode |-> ##[1:4] mgmt_mode; endproperty
   a_ext: assert property (p_ext) else $error("external request ignored");
   property p_ack; !avs_waitrequest |=> avs_waitrequest; endproperty
   a_ack: assert property (p_ack) else $error("waitrequest low too long");
endmodule
bind pmi_ctrl pmi_ctrl_props u_props (.clk_sys, .rst_n, .ext_req, .mem_addr, .avs_waitrequest, .mgmt_mode,
   .mgmt_irq_take, .nmi_take, .intr_take, .pmem_enable, .pmem_hit, .state_save, .state_restore,
   .mgmt_stack_sel, .force_real);

/* tb/power_mgmt_interrupt_control_tb.sv */
`timescale 1ns/1ps
`include "pmi_consts.svh"
module power_mgmt_interrupt_control_tb;
   logic        clk_sys, rst_n, avs_read, avs_write, avs_waitrequest, io_valid, io_write, mem_valid;
   logic        xbus_irq, ext_req, nmi_req, intr_req, core_ack, resume_exec, mgmt_mode, mgmt_irq_take;
   logic        nmi_take, intr_take, pmem_enable, pmem_hit, state_save, state_restore, mgmt_stack_sel;
   logic        force_real, backlight_on, disp_refresh, irq;
   logic [7:0]  avs_address, io_opcode, op;
   logic [31:0] avs_writedata, avs_readdata, msk, v;
   logic [15:0] io_port;
   logic [23:0] mem_addr;
   logic [5:0]  periph_access;
   logic [1:0]  core_opmode, h;
   logic [63:0] sb[$];
   int          num_errors = 0, check_count = 0, n;
   pmi_ctrl #(.STEP_CYC(10)) u_dut (.clk_sys, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_readdata, .avs_waitrequest, .io_valid, .io_write, .io_port, .io_opcode, .mem_valid, .mem_addr,
      .periph_access, .xbus_irq, .ext_req, .nmi_req, .intr_req, .core_ack, .resume_exec, .core_opmode,
      .mgmt_mode, .mgmt_irq_take, .nmi_take, .intr_take, .pmem_enable, .pmem_hit, .state_save,
      .state_restore, .mgmt_stack_sel, .force_real, .backlight_on, .disp_refresh, .irq);
   pmi_core_mdl u_core (.clk_sys, .rst_n, .state_save, .state_restore, .core_ack, .core_opmode);
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] t=%0t seen=%h expected=%h", $time, got, exp);
      end
   endtask
   task automatic results();
      $display("checks=%0d mismatches=%0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // Reads note {mask, expected}; only masked bits are judged
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [31:0] m);
      int k;
      avs_address   <= a;
      avs_write     <= w;
      avs_read      <= !w;
      avs_writedata <= d;
      if (!w) sb.push_back({m, d & m});
      k = 0;
      // Waitrequest is judged mid-cycle; the next rising edge completes the access
      do begin
         @(negedge clk_sys);
         k++;
      end while (avs_waitrequest !== 1'b0 && k < 50);
      @(posedge clk_sys);
      if (k >= 50) num_errors++;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk_sys);
   endtask
   always @(negedge clk_sys) begin
      if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && sb.size() > 0) begin
         chk(avs_readdata & sb[0][63:32], sb[0][31:0]);
         void'(sb.pop_front());
      end
   end
   task automatic io(input logic [15:0] p, input logic [7:0] o);
      io_valid  <= 1'b1;
      io_port   <= p;
      io_opcode <= o;
      io_write  <= 1'($urandom_range(1));
      @(posedge clk_sys);
      io_valid <= 1'b0;
   endtask
   // Hit and irq are taken mid-cycle, while the registered hit stands
   task automatic mem(input logic [23:0] a, output logic [1:0] hv);
      mem_valid <= 1'b1;
      mem_addr  <= a;
      @(posedge clk_sys);
      mem_valid <= 1'b0;
      @(negedge clk_sys);
      hv = {pmem_hit, irq};
      @(posedge clk_sys);
   endtask
   task automatic wait_mode(input logic e);
      n = 0;
      while (mgmt_mode !== e && n < 60) begin
         @(negedge clk_sys);
         n++;
      end
      chk({31'h0, mgmt_mode}, {31'h0, e});
      @(posedge clk_sys);
   endtask
   task automatic serve(input logic [31:0] st);
      wait_mode(1'b1);
      n = 0;
      while (force_real !== 1'b1 && n < 20) begin
         @(negedge clk_sys);
         n++;
      end
      chk({30'h0, force_real, irq}, {30'h0, 1'b1, |(st & msk)});
      @(posedge clk_sys);
      mem(24'h03_0000 | 24'($urandom_range(16'hffff)), h);
      chk({31'h0, h[1]}, 32'h1);
      bus(`PMI_A_STATUS, 1'b0, st, st);
      bus(`PMI_A_STATUS, 1'b0, 32'h0, st);
      bus(`PMI_A_ENABLE, 1'b1, 32'h0, 32'h0);
      resume_exec <= 1'b1;
      @(posedge clk_sys);
      resume_exec <= 1'b0;
      wait_mode(1'b0);
      mem(24'h03_0000, h);
      chk({30'h0, h}, 32'h0);
      chk({31'h0, nmi_take}, {31'h0, nmi_req});
   endtask
   initial begin
      {rst_n, avs_read, avs_write, io_valid, io_write, mem_valid, xbus_irq, ext_req} = '0;
      {nmi_req, intr_req, resume_exec, avs_address, avs_writedata, io_port, io_opcode} = '0;
      {mem_addr, periph_access, msk} = '0;
      void'($urandom(32'h0214_f73d));
      repeat (8) @(posedge clk_sys);
      rst_n <= 1'b1;
      @(posedge clk_sys);
      chk({26'h0, mgmt_mode, pmem_enable, force_real, backlight_on, irq, avs_waitrequest}, 32'h1);
      bus(`PMI_A_ENABLE, 1'b0, 32'h0, 32'hffff_ffff);
      bus(`PMI_A_MASK, 1'b0, 32'h0, 32'hffff_ffff);
      bus(8'hfc, 1'b0, 32'h0, 32'hffff_ffff);
      $display("reset test done");
      v = 32'h0100 + 32'($urandom_range(16'h0eff));
      bus(`PMI_A_RNG_LO, 1'b1, v, 32'h0);
      bus(`PMI_A_RNG_HI, 1'b1, v + 3, 32'h0);
      bus(`PMI_A_ENABLE, 1'b1, 32'h1, 32'h0);
      io(v[15:0] + 16'($urandom_range(3)), 8'h00);
      serve(32'h1);
      xbus_irq <= 1'b1;
      @(posedge clk_sys);
      xbus_irq <= 1'b0;
      repeat (10) @(posedge clk_sys);
      chk({31'h0, mgmt_mode}, 32'h0);
      bus(`PMI_A_STATUS, 1'b0, 32'h1000, 32'h1000);
      bus(`PMI_A_ENABLE, 1'b1, 32'h1000, 32'h0);
      xbus_irq <= 1'b1;
      @(posedge clk_sys);
      xbus_irq <= 1'b0;
      serve(32'h1000);
      $display("range and bus test done");
      msk = 32'h2000;
      bus(`PMI_A_MASK, 1'b1, msk, 32'h0);
      {nmi_req, intr_req, ext_req} <= 3'h7;
      @(posedge clk_sys);
      ext_req <= 1'b0;
      serve(32'h2000);
      {nmi_req, intr_req} <= 2'h0;
      v = 32'h1000 + 32'($urandom_range(16'h0fff));
      // Only six powered-down slots exist
      v[2:0] = 3'($urandom_range(5));
      op = 8'($urandom_range(8'hff));
      bus(`PMI_A_PWRDN, 1'b1, 32'h1 << v[2:0], 32'h0);
      io(v[15:0], op);
      serve(32'h4000);
      bus(`PMI_A_TRAP_OP, 1'b0, {24'h0, op}, 32'h00ff);
      bus(`PMI_A_TRAP_PORT, 1'b0, v, 32'hffff);
      bus(`PMI_A_PWRDN, 1'b0, 32'h1 << v[2:0], 32'h3f);
      bus(`PMI_A_PWRDN, 1'b1, 32'h0, 32'h0);
      $display("external and trap test done");
      bus(`PMI_A_TMR_RLD, 1'b1, 32'h2, 32'h0);
      bus(`PMI_A_ENABLE, 1'b1, 32'h40, 32'h0);
      repeat (6) begin
         periph_access <= 6'h01;
         @(posedge clk_sys);
         periph_access <= 6'h00;
         repeat (9) @(posedge clk_sys);
      end
      chk({31'h0, mgmt_mode}, 32'h0);
      serve(32'h40);
      bus(`PMI_A_TMR_RLD, 1'b1, 32'h0, 32'h0);
      mem(24'h0a_0000 | 24'($urandom_range(17'h1_ffff)), h);
      repeat (2) @(posedge clk_sys);
      chk({31'h0, backlight_on}, 32'h1);
      // 780 cycles holds exactly two refresh periods whatever the phase
      n = 0;
      repeat (780) begin
         @(posedge clk_sys);
         if (disp_refresh === 1'b1) n++;
      end
      chk(32'(n), 32'h2);
      $display("timer and display test done");
      results();
   end
   // Tests need just over a thousand cycles; nearly twenty times that means a hang
   initial begin
      repeat (20000) @(posedge clk_sys);
      num_errors++;
      results();
   end
endmodule
